// File: design/chb_host_port.sv
// host bus port, arbitration and interrupt chains, forced sync outputs
`include "chb_defines.svh"
module chb_host_port import chb_pkg::*; (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // multiplexed address/data bus
    input  wire logic [15:0] muxedAddrDataIn,
    output logic      [15:0] muxedAddrDataOut,
    output logic             muxedAddrDataOe,
    // strobes and direction
    input  wire logic        addressStrobeNIn,
    output logic             addressStrobeNOut,
    output logic             addressStrobeNOe,
    input  wire logic        dataStrobeNIn,
    output logic             dataStrobeNOut,
    output logic             dataStrobeNOe,
    input  wire logic        readWriteIn,
    output logic             readWriteOut,
    output logic             readWriteOe,
    input  wire logic        chipSelectN,
    input  wire logic        commandData,
    input  wire logic        waitN,
    // transceiver enables, open drain
    output logic             transmitEnableNOut,
    output logic             transmitEnableNOe,
    output logic             receiveEnableNOut,
    output logic             receiveEnableNOe,
    // bus arbitration
    input  wire logic        busRequestNIn,
    output logic             busRequestNOut,
    output logic             busRequestNOe,
    input  wire logic        busAckInN,
    output logic             busAckOutN,
    // interrupt chain
    output logic             interruptNOut,
    output logic             interruptNOe,
    input  wire logic        interruptAckN,
    input  wire logic        irqChainEnableIn,
    output logic             irqChainEnableOut,
    // video pins
    output logic             hsync,
    output logic             vsync,
    output logic             blank,
    input  wire logic        externalLineSyncIn,
    input  wire logic        testResetN,
    input  wire logic        characterClockIn,
    // timing generator side
    input  wire logic        hsyncGen,
    input  wire logic        vsyncGen,
    input  wire logic        blankGen,
    output logic             counterClear,
    output logic             lineSyncPulse,
    output logic             charTick,
    // register side
    output logic [15:0]      mode1,
    output logic [15:0]      mode2,
    output logic [4:0]       regPointer,
    output logic             regWrite,
    output logic [15:0]      regWrData,
    input  wire logic [15:0] regRdData,
    // master cycle request side
    input  wire logic        dmaValid,
    input  wire logic [1:0]  dmaKind,
    input  wire logic [15:0] dmaAddr,
    input  wire logic [7:0]  dmaHiAddr,
    output logic             dmaDone,
    output logic [15:0]      dmaRdData,
    output logic             busMaster,
    // interrupt source
    input  wire logic        irqEvent,
    input  wire logic [7:0]  irqVector
);
    // synchronised pins
    logic [15:0] adS;
    logic [12:0] ctlS;
    logic        asS, dsS, rwS, csS, cdS, waitS, brqS, baiS, iackS, ieiS, esyncS, trstS, cclkS;

    // all pin inputs and the character clock pass two flops before use
    chb_sync2 #(.W(16), .INIT(16'h0000)) u_sync_ad (
        .core_clk (core_clk),
        .nrst     (nrst),
        .asyncIn  (muxedAddrDataIn),
        .syncOut  (adS)
    );
    chb_sync2 #(.W(13), .INIT(13'h1_FFF)) u_sync_ctl (
        .core_clk (core_clk),
        .nrst     (nrst),
        .asyncIn  ({addressStrobeNIn, dataStrobeNIn, readWriteIn, chipSelectN, commandData, waitN,
                    busRequestNIn, busAckInN, interruptAckN, irqChainEnableIn, externalLineSyncIn,
                    testResetN, characterClockIn}),
        .syncOut  (ctlS)
    );
    assign {asS, dsS, rwS, csS, cdS, waitS, brqS, baiS, iackS, ieiS, esyncS, trstS, cclkS} = ctlS;

    // state
    chb_dma_e    st_q;
    logic        master_q;
    logic [1:0]  settle_q;
    logic [1:0]  hold_q;
    chb_kind_e   kind_q;
    logic        csLat_q, cdLat_q;
    logic        dsPrev_q, esPrev_q, cclkPrev_q;
    logic        irqPend_q;
    logic        hs_q, vs_q, bl_q;
    logic [15:0] mode1_q, mode2_q, rdData_q, dmaRd_q;
    logic [4:0]  ptr_q;
    logic        regWr_q, dmaDone_q, lineSync_q, charTick_q;
    logic [15:0] regWrData_q;

    // decode
    logic sel, slaveRd, slaveWrEnd, vecAck, vecOut, needBus;
    assign sel        = !csLat_q && !master_q;
    assign slaveRd    = sel && !dsS && rwS;
    assign slaveWrEnd = sel && dsS && !dsPrev_q && !rwS;
    assign vecAck     = !iackS && ieiS && irqPend_q && !master_q;
    assign vecOut     = vecAck && !dsS;
    assign needBus    = st_q != CHB_IDLE && st_q != CHB_HOLD;

    // select latch: transparent while strobe low or while master, otherwise holds from its rising edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            csLat_q <= 1'b1;
            cdLat_q <= 1'b0;
        end else if (!asS || master_q) begin
            csLat_q <= csS;
            cdLat_q <= cdS;
        end
    end

    // edge history of the data strobe, line sync and character clock
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dsPrev_q   <= 1'b1;
            esPrev_q   <= 1'b1;   // same as synchroniser reset, so no false edge follows reset
            cclkPrev_q <= 1'b1;
        end else begin
            dsPrev_q   <= dsS;
            esPrev_q   <= esyncS;
            cclkPrev_q <= cclkS;
        end
    end

    // pointer and mode registers; strobe is async so the write lands after sync delay
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q       <= 5'h00;
            mode1_q     <= `CHB_MODE1_RST;
            mode2_q     <= `CHB_MODE2_RST;
            regWr_q     <= 1'b0;
            regWrData_q <= 16'h0000;
        end else begin
            regWr_q <= 1'b0;
            if (slaveWrEnd && cdLat_q) begin
                ptr_q <= adS[`CHB_PTR_W-1:0];
            end else if (slaveWrEnd) begin
                regWr_q     <= 1'b1;
                regWrData_q <= adS;
                if (ptr_q == `CHB_PTR_MODE1) begin
                    mode1_q <= adS;
                end
                if (ptr_q == `CHB_PTR_MODE2) begin
                    mode2_q <= adS;
                end
            end
            if (!trstS) begin
                mode2_q[`CHB_MODE2_TRST_MSB:0] <= '0;
            end
        end
    end

    // read data register, refreshed each cycle: vector in acknowledge, pointer when command, else the pointed source
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 16'h0000;
        end else if (vecAck) begin
            rdData_q <= {8'h00, irqVector};
        end else if (cdLat_q) begin
            rdData_q <= {11'h000, ptr_q};
        end else if (ptr_q == `CHB_PTR_MODE1) begin
            rdData_q <= mode1_q;
        end else if (ptr_q == `CHB_PTR_MODE2) begin
            rdData_q <= mode2_q;
        end else begin
            rdData_q <= regRdData;
        end
    end

    // master cycle sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q      <= CHB_IDLE;
            master_q  <= 1'b0;
            settle_q  <= 2'h0;
            hold_q    <= 2'h0;
            kind_q    <= CHB_KIND_READ;
            dmaDone_q <= 1'b0;
            dmaRd_q   <= 16'h0000;
        end else begin
            dmaDone_q <= 1'b0;
            unique case (st_q)
                CHB_IDLE: begin
                    if (dmaValid) begin
                        st_q <= CHB_REQ;
                    end
                end
                CHB_REQ: begin
                    if (!baiS) begin
                        master_q <= 1'b1;
                        st_q     <= CHB_T1;
                        kind_q   <= chb_kind_e'(dmaKind);
                    end
                end
                CHB_T1: begin
                    st_q     <= CHB_T2;
                    settle_q <= 2'h0;
                end
                CHB_T2: begin
                    // stretch memory reads only
                    if (waitS || kind_q != CHB_KIND_READ) begin
                        st_q <= CHB_T3;
                    end
                end
                CHB_T3: begin
                    if (settle_q != `CHB_RD_SETTLE_CYC) begin
                        settle_q <= settle_q + 2'h1;
                    end else begin
                        dmaDone_q <= 1'b1;
                        dmaRd_q   <= adS;
                        if (dmaValid && !baiS) begin
                            st_q   <= CHB_T1;
                            kind_q <= chb_kind_e'(dmaKind);
                        end else begin
                            // release the bus, then keep off it
                            master_q <= 1'b0;
                            hold_q   <= 2'h1;
                            st_q     <= CHB_HOLD;
                        end
                    end
                end
                CHB_HOLD: begin
                    if (hold_q != 2'(`CHB_HOLDOFF_CYC)) begin
                        hold_q <= hold_q + 2'h1;
                    end else if (dmaValid && brqS) begin
                        st_q <= CHB_REQ;
                    end else if (!dmaValid) begin
                        st_q <= CHB_IDLE;
                    end
                end
                default: st_q <= CHB_IDLE;
            endcase
        end
    end

    // interrupt pending: an event in the ack cycle wins over the clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irqPend_q <= 1'b0;
        end else if (irqEvent) begin
            irqPend_q <= 1'b1;
        end else if (vecAck && dsS && !dsPrev_q) begin
            irqPend_q <= 1'b0;
        end
    end

    // sync outputs forced safe under reset and test reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            bl_q <= 1'b1;
        end else if (!trstS) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            bl_q <= 1'b1;
        end else begin
            hs_q <= hsyncGen;
            vs_q <= vsyncGen;
            bl_q <= blankGen;
        end
    end

    // line sync and character clock events; line sync never reaches hsync
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lineSync_q <= 1'b0;
            charTick_q <= 1'b0;
        end else begin
            lineSync_q <= mode1_q[`CHB_MODE1_ES_BIT] && esyncS && !esPrev_q;
            charTick_q <= cclkS && !cclkPrev_q;
        end
    end

    // master drive: address in T1, data strobe low T2..T3 on reads only
    always_comb begin
        muxedAddrDataOut = rdData_q;
        muxedAddrDataOe  = slaveRd || vecOut;
        addressStrobeNOut = 1'b1;
        dataStrobeNOut    = 1'b1;
        readWriteOut      = 1'b1;
        if (master_q) begin
            muxedAddrDataOut = (kind_q == CHB_KIND_PAGE) ? {8'h00, dmaHiAddr} : dmaAddr;
            muxedAddrDataOe  = (st_q == CHB_T1);
            addressStrobeNOut = (st_q != CHB_T1);
            dataStrobeNOut    = !((st_q == CHB_T2 || st_q == CHB_T3) && kind_q == CHB_KIND_READ);
            readWriteOut      = (kind_q != CHB_KIND_PAGE);
        end
    end

    // strobes tri-stated unless master
    assign addressStrobeNOe = master_q;
    assign dataStrobeNOe    = master_q;
    assign readWriteOe      = master_q;

    // transceiver enables; the receive enable is masked while the transmit enable is on
    logic txOn, rxOn;
    assign txOn = master_q ? (st_q == CHB_T1) : (slaveRd || vecOut);
    assign rxOn = master_q ? (kind_q == CHB_KIND_READ && (st_q == CHB_T2 || st_q == CHB_T3))
                           : (sel && !dsS && !rwS);
    assign transmitEnableNOut = 1'b0;
    assign transmitEnableNOe  = txOn;
    assign receiveEnableNOut  = 1'b0;
    assign receiveEnableNOe   = rxOn && !txOn;

    // arbitration pins
    assign busRequestNOut = 1'b0;
    assign busRequestNOe  = needBus;
    assign busAckOutN     = needBus ? 1'b1 : baiS;

    // interrupt chain
    assign interruptNOut     = 1'b0;
    assign interruptNOe      = irqPend_q;
    assign irqChainEnableOut = ieiS && !irqPend_q;

    // user-side outputs
    assign hsync         = hs_q;
    assign vsync         = vs_q;
    assign blank         = bl_q;
    assign counterClear  = !trstS;
    assign lineSyncPulse = lineSync_q;
    assign charTick      = charTick_q;
    assign mode1         = mode1_q;
    assign mode2         = mode2_q;
    assign regPointer    = ptr_q;
    assign regWrite      = regWr_q;
    assign regWrData     = regWrData_q;
    assign dmaDone       = dmaDone_q;
    assign dmaRdData     = dmaRd_q;
    assign busMaster     = master_q;
endmodule

// File: design/chb_sync2.sv
// two flip-flop synchroniser for pin and foreign-clock inputs
module chb_sync2 #(
    parameter int unsigned W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // async in, synced out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q  <= INIT;
            syncOut <= INIT;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// File: dv/chb_host_model.sv
// host side model: slave transfers, bus arbiter and memory answers
module chb_host_model #(
    parameter logic [15:0] MEM_WORD = 16'hA5C3
) (
    // clock
    input  wire logic        core_clk,
    // resolved pin levels
    input  wire logic [15:0] adPin,
    input  wire logic        dsPin,
    input  wire logic        rwPin,
    input  wire logic        brqPin,
    input  wire logic        dsDriven,
    input  wire logic        grantOn,
    // host drive
    output logic      [15:0] hostAd,
    output logic             hostAdOe,
    output logic             hostDsN,
    output logic             hostRw,
    output logic             chipSelN,
    output logic             cmdData,
    output logic             baiN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        slaveDrive = 1'b0;
    logic [15:0] slaveWord  = 16'h0000;
    initial begin
        hostDsN  = 1'b1;
        hostRw   = 1'b1;
        chipSelN = 1'b1;
        cmdData  = 1'b0;
        baiN     = 1'b1;
    end
    // memory answers only while the device strobes a read, then lets go
    assign hostAdOe = slaveDrive || (dsDriven && !dsPin && rwPin);
    assign hostAd   = slaveDrive ? slaveWord : MEM_WORD;
    // arbiter grants the chain while grantOn is set and the shared request line is low
    always @(posedge core_clk) begin
        baiN <= !(grantOn && !brqPin);
    end
    // one slave transfer; select and data outlast the strobe by five clocks
    task automatic access(input logic cmd, input logic rd, input logic [15:0] wd, output logic [15:0] rv);
        @(negedge core_clk);
        chipSelN   = 1'b0;
        cmdData    = cmd;
        hostRw     = rd;
        slaveWord  = wd;
        slaveDrive = !rd;
        @(negedge core_clk);
        hostDsN = 1'b0;
        repeat (6) @(negedge core_clk);
        rv      = adPin;
        hostDsN = 1'b1;
        repeat (5) @(negedge core_clk);
        chipSelN   = 1'b1;
        slaveDrive = 1'b0;
        cmdData    = 1'b0;
    endtask
endmodule

// File: dv/chb_host_port_chk.sv
// assertions on the host port pins
module chb_host_port_chk import chb_pkg::*; (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // watched ports
    input wire logic       busAckInN,
    input wire logic       testResetN,
    input wire logic       irqChainEnableIn,
    input wire logic       interruptAckN,
    input wire logic [1:0] dmaKind,
    input wire logic       muxedAddrDataOe,
    input wire logic       addressStrobeNOut,
    input wire logic       readWriteOut,
    input wire logic       readWriteOe,
    input wire logic       transmitEnableNOe,
    input wire logic       receiveEnableNOe,
    input wire logic       busRequestNOe,
    input wire logic       busAckOutN,
    input wire logic       busMaster,
    input wire logic       interruptNOe,
    input wire logic       irqChainEnableOut,
    input wire logic       hsync,
    input wire logic       vsync,
    input wire logic       blank,
    input wire logic       counterClear
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    chk_reset_state: assert property ($rose(nrst) |-> !hsync && !vsync && blank && !muxedAddrDataOe)
        else $error("outputs not in reset state");
    chk_enables_apart: assert property (!(transmitEnableNOe && receiveEnableNOe))
        else $error("both transceiver enables low");
    chk_master_requests: assert property (busMaster |-> busRequestNOe && busAckOutN)
        else $error("master without request or with open acknowledge");
    chk_ack_ripples: assert property ((!busRequestNOe && !busAckInN) [*3] |-> !busAckOutN)
        else $error("acknowledge not passed on");
    chk_grant_synced: assert property ($rose(busMaster) |-> !$past(busAckInN, 3))
        else $error("grant taken before two clocks");
    chk_release_gap: assert property ($fell(busRequestNOe) |-> !busRequestNOe [*3])
        else $error("bus request back too soon");
    chk_dummy_reads: assert property (readWriteOe && dmaKind == CHB_KIND_DUMMY |-> readWriteOut)
        else $error("dummy cycle not reading");
    chk_rw_steady: assert property (readWriteOe && $past(readWriteOe) && addressStrobeNOut |-> $stable(readWriteOut))
        else $error("direction moved in a cycle");
    chk_addr_phase: assert property (readWriteOe && !addressStrobeNOut |-> muxedAddrDataOe && transmitEnableNOe)
        else $error("address strobe without address drive");
    chk_irq_holds: assert property (interruptNOe && $past(interruptAckN, 2) |=> interruptNOe)
        else $error("interrupt dropped without acknowledge");
    chk_chain_copies: assert property ((!interruptNOe && irqChainEnableIn) [*3] |-> irqChainEnableOut)
        else $error("chain enable not copied");
    chk_test_reset: assert property (!testResetN [*5] |-> !hsync && !vsync && blank && counterClear)
        else $error("test reset not forcing outputs");
endmodule
bind chb_host_port chb_host_port_chk chb_host_port_chk_inst (.*);

// File: dv/test_crtc_host_bus_and_sync_pins.sv
// self-checking bench for the host bus port block
`include "chb_defines.svh"
module test_crtc_host_bus_and_sync_pins;
    timeunit 1ns;
    timeprecision 1ps;
    import chb_pkg::*;
    localparam logic [15:0] DMA_ADDR = 16'h3C5A;
    localparam logic [7:0]  DMA_HI   = 8'h96;
    localparam logic [7:0]  IRQ_VEC  = 8'h4B;
    localparam logic [15:0] REG_WORD = 16'hBEEF;
    localparam logic [15:0] MEM_WORD = 16'hA5C3;
    logic        core_clk = 1'b0, nrst = 1'b0, waitN = 1'b1, irqAckN = 1'b1, ieiIn = 1'b1, irqEvent = 1'b0;
    logic        lineSync = 1'b0, testResetN = 1'b1, charClk = 1'b0, dmaValid = 1'b0, grantOn = 1'b0;
    logic        hsyncGen = 1'b1, vsyncGen = 1'b1, blankGen = 1'b0, otherReq = 1'b0;
    logic [1:0]  dmaKind = CHB_KIND_READ;
    logic [15:0] adLast = 16'h0000, lsCount = 16'h0000, doneCount = 16'h0000;
    logic [15:0] adOut, hAd, rdVal, asAddr, mode1, mode2, dmaRd, wrData;
    logic        adOe, asOut, asOe, dsOut, dsOe, rwOut, rwOe, brqOe, baoN, intOe, irq_chain_enable_out, hAdOe, hDsN, hRw;
    logic        hsync, vsync, blank, cntClr, lsPulse, dmaDone, busMaster, csN, cmd, baiN;
    int          fail_count = 0, check_count = 0, cycles = 0;
    // released address/data lines show the inverse of their last level
    wire  [15:0] adPin  = adOe ? adOut : hAdOe ? hAd : ~adLast;
    wire         dsPin  = dsOe ? dsOut : hDsN;
    wire         rwPin  = rwOe ? rwOut : hRw;
    wire         asPin  = asOe ? asOut : 1'b0;
    wire         brqPin = !(brqOe || otherReq);
    initial forever #12.5 core_clk = ~core_clk;
    // character clock unrelated to the system clock
    initial forever #19 charClk = ~charClk;
    chb_host_port chb_host_port_inst (
        .core_clk(core_clk), .nrst(nrst), .muxedAddrDataIn(adPin), .muxedAddrDataOut(adOut),
        .muxedAddrDataOe(adOe), .addressStrobeNIn(asPin), .addressStrobeNOut(asOut), .addressStrobeNOe(asOe),
        .dataStrobeNIn(dsPin), .dataStrobeNOut(dsOut), .dataStrobeNOe(dsOe), .readWriteIn(rwPin),
        .readWriteOut(rwOut), .readWriteOe(rwOe), .chipSelectN(csN), .commandData(cmd), .waitN(waitN),
        .transmitEnableNOut(), .transmitEnableNOe(), .receiveEnableNOut(), .receiveEnableNOe(),
        .busRequestNIn(brqPin), .busRequestNOut(), .busRequestNOe(brqOe), .busAckInN(baiN), .busAckOutN(baoN),
        .interruptNOut(), .interruptNOe(intOe), .interruptAckN(irqAckN), .irqChainEnableIn(ieiIn),
        .irqChainEnableOut(irq_chain_enable_out), .hsync(hsync), .vsync(vsync), .blank(blank), .externalLineSyncIn(lineSync),
        .testResetN(testResetN), .characterClockIn(charClk), .hsyncGen(hsyncGen), .vsyncGen(vsyncGen),
        .blankGen(blankGen), .counterClear(cntClr), .lineSyncPulse(lsPulse), .charTick(), .mode1(mode1),
        .mode2(mode2), .regPointer(), .regWrite(), .regWrData(wrData), .regRdData(REG_WORD), .dmaValid(dmaValid),
        .dmaKind(dmaKind), .dmaAddr(DMA_ADDR), .dmaHiAddr(DMA_HI), .dmaDone(dmaDone), .dmaRdData(dmaRd),
        .busMaster(busMaster), .irqEvent(irqEvent), .irqVector(IRQ_VEC));
    chb_host_model #(.MEM_WORD(MEM_WORD)) chb_host_model_inst (
        .core_clk(core_clk), .adPin(adPin), .dsPin(dsPin), .rwPin(rwPin), .brqPin(brqPin), .dsDriven(dsOe),
        .grantOn(grantOn), .hostAd(hAd), .hostAdOe(hAdOe), .hostDsN(hDsN), .hostRw(hRw), .chipSelN(csN),
        .cmdData(cmd), .baiN(baiN));
    // pin bookkeeping for the scenarios, plus the hang limit
    always @(posedge core_clk) begin
        adLast <= adPin;
        cycles <= cycles + 1;
        if (asOe && !asOut) asAddr <= adPin;
        if (lsPulse === 1'b1) lsCount <= lsCount + 16'h0001;
        if (dmaDone === 1'b1) doneCount <= doneCount + 16'h0001;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic acc(input logic c, input logic rd, input logic [15:0] wd);
        chb_host_model_inst.access(c, rd, wd, rdVal);
    endtask
    // bounded wait for one finished master cycle
    task automatic wait_done();
        int n = 0;
        while (dmaDone !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check("cycle done", dmaDone, 1'b1);
        idle(1);
    endtask
    task automatic t_reset();
        check("reset pins", {hsync, vsync, blank, adOe, brqOe, baoN}, 16'h0009);
        check("first mode", mode1, 16'h0000);
    endtask
    // pointer then data, read back, pointer read, other register
    task automatic t_regs();
        acc(1'b1, 1'b0, {11'h000, `CHB_PTR_MODE2});
        acc(1'b0, 1'b0, 16'h1234);
        check("second mode", mode2, 16'h1234);
        check("write data", wrData, 16'h1234);
        acc(1'b0, 1'b1, 16'h0000);
        check("second mode read", rdVal, 16'h1234);
        acc(1'b1, 1'b1, 16'h0000);
        check("pointer read", {11'h000, rdVal[4:0]}, {11'h000, `CHB_PTR_MODE2});
        acc(1'b1, 1'b0, 16'h0007);
        acc(1'b0, 1'b1, 16'h0000);
        check("other register", rdVal, REG_WORD);
    endtask
    task automatic t_test_reset();
        testResetN = 1'b0;
        idle(6);
        check("forced syncs", {hsync, vsync, blank, cntClr}, 4'h3);
        check("second mode cleared", mode2, 16'h1200);
        testResetN = 1'b1;
        idle(6);
        check("syncs follow", {hsync, vsync, blank, cntClr}, 4'hC);
    endtask
    // first pass with the enable bit clear, second with it set
    task automatic t_line_sync();
        for (int i = 0; i < 2; i++) begin
            lineSync = 1'b1;
            idle(5);
            lineSync = 1'b0;
            idle(5);
            check("line sync pulses", lsCount, {15'h0000, i[0]});
            check("hsync untouched", hsync, 1'b1);
            acc(1'b1, 1'b0, {11'h000, `CHB_PTR_MODE1});
            acc(1'b0, 1'b0, 16'h0001 << `CHB_MODE1_ES_BIT);
        end
    endtask
    task automatic t_irq();
        irqEvent = 1'b1;
        idle(1);
        irqEvent = 1'b0;
        idle(4);
        check("request blocks chain", {intOe, irq_chain_enable_out}, 2'h2);
        irqAckN = 1'b0;
        idle(3);
        acc(1'b0, 1'b1, 16'h0000);
        check("vector", rdVal[7:0], IRQ_VEC);
        irqAckN = 1'b1;
        idle(4);
        check("request served", {intOe, irq_chain_enable_out}, 2'h1);
        ieiIn = 1'b0;
        idle(4);
        check("chain blocked", irq_chain_enable_out, 1'b0);
        ieiIn = 1'b1;
    endtask
    task automatic t_dma();
        logic [15:0] doneBase;
        otherReq = 1'b1;
        grantOn  = 1'b1;
        idle(5);
        check("acknowledge ripples", baoN, 1'b0);
        otherReq = 1'b0;
        idle(4);
        dmaValid = 1'b1;
        wait_done();
        check("read data", dmaRd, MEM_WORD);
        check("read address", asAddr, DMA_ADDR);
        check("acknowledge forced", {busMaster, baoN}, 2'h3);
        waitN = 1'b0;
        wait_done(); // the cycle already past its wait sample still ends
        doneBase = doneCount;
        idle(12);
        check("wait stretches", doneCount, doneBase);
        dmaKind = CHB_KIND_DUMMY;
        waitN   = 1'b1;
        wait_done();
        waitN = 1'b0;
        wait_done();
        dmaKind = CHB_KIND_PAGE;
        wait_done();
        wait_done();
        check("page address", asAddr, {8'h00, DMA_HI});
        otherReq = 1'b1;
        grantOn  = 1'b0;
        idle(14);
        check("off the bus", {busMaster, brqOe}, 2'h0);
        otherReq = 1'b0;
        idle(6);
        check("requests again", brqOe, 1'b1);
        dmaValid = 1'b0;
        grantOn  = 1'b1;
        idle(30);
        check("request dropped", brqOe, 1'b0);
    endtask
    initial begin
        idle(10);
        t_reset();
        idle(2);
        nrst = 1'b1;
        idle(3);
        t_regs();
        t_test_reset();
        t_line_sync();
        t_irq();
        t_dma();
        give_verdict();
    end
endmodule

// File: shared/chb_defines.svh
// constants for the host bus and sync pin block
`ifndef CHB_DEFINES_SVH
`define CHB_DEFINES_SVH

// register pointer values
`define CHB_PTR_MODE1        5'h00
`define CHB_PTR_MODE2        5'h01
`define CHB_PTR_W            5

// field positions
`define CHB_MODE1_ES_BIT     4
`define CHB_MODE2_TRST_MSB   8

// reset values
`define CHB_MODE1_RST        16'h0000
`define CHB_MODE2_RST        16'h0000
`define CHB_VEC_RST          8'h00

// timing
`define CHB_CLK_PERIOD_NS    25
`define CHB_HOLDOFF_CYC      3
`define CHB_RESET_MIN_CYC    5
`define CHB_RD_SETTLE_CYC    2'h2
`define CHB_SYNC_STAGES      2
`endif

// File: shared/chb_pkg.sv
// types for the host bus and sync pin block
package chb_pkg;
    // master cycle sequencer
    typedef enum logic [2:0] {
        CHB_IDLE = 3'b000,
        CHB_REQ  = 3'b001,
        CHB_T1   = 3'b010,
        CHB_T2   = 3'b011,
        CHB_T3   = 3'b100,
        CHB_HOLD = 3'b101
    } chb_dma_e;

    // kind of master cycle
    typedef enum logic [1:0] {
        CHB_KIND_READ  = 2'b00,
        CHB_KIND_PAGE  = 2'b01,
        CHB_KIND_DUMMY = 2'b10
    } chb_kind_e;
endpackage
